// ==== rtl/obcfg_decoder.sv ====
// Option byte configuration decoder: holds the two option bytes, decodes them into
// fixed device configuration, gates program-memory reads and passes data-EEPROM reads through.
// Assumes a programming port that is live only in programming mode, synchronous inputs.
`timescale 1ns/1ns
`default_nettype none

`include "obcfg_map.svh"

module obcfg_decoder
	import obcfg_pkg::*;
#(
	parameter int         ADDR_W      = `OBCFG_MEM_ADDR_W,
	parameter bit         MASK_ROM    = 1'b0,
	parameter logic [7:0] ROM_BYTE0   = `OBCFG_B0_DEFAULT,
	parameter logic [7:0] ROM_BYTE1   = `OBCFG_B1_DEFAULT
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// Programming port (valid only in programming mode)
	input  wire logic              prog_mode,
	input  wire logic              opt_wr,
	input  wire logic              opt_sel,
	input  wire logic [7:0]        opt_wdata,
	output logic [7:0]             opt_rdata,
	// External memory read path
	input  wire logic              ext_mem_rd,
	input  wire logic              ext_ee_rd,
	input  wire logic              cell_erased,
	input  wire logic [7:0]        mem_rdata,
	output logic [7:0]             ext_rdata,
	output logic                   ext_blocked,
	// Wipe write port to program memory
	output logic                   wipe_we,
	output logic [ADDR_W-1:0]      wipe_addr,
	output logic                   wipe_busy,
	// Halt and watchdog
	input  wire logic              halt_entry,
	input  wire logic              watchdog_mode_bit_enable,
	output logic                   wdg_active,
	output logic                   halt_reset_req,
	// Decoded configuration
	output logic                   pkg_large,
	output logic                   read_protect_bit,
	output logic                   clock_guard_en,
	output obcfg_osc_type          main_clock_source_select,
	output obcfg_bor_type          brownout_threshold_select,
	output logic                   halt_entry_reset_bit,
	output logic                   watchdog_mode_bit
);

	// ----------------------------------------
	// Option byte storage
	// ----------------------------------------
	// Non-volatile cells; shipped erased (all ones) and kept across rst_n.
	// The declaration value stands in for the power-up state of the cells.
	logic [7:0] nv0_q = `OBCFG_ERASED_BYTE;
	logic [7:0] nv1_q = `OBCFG_ERASED_BYTE;
	// Reset-time copies that drive all decoding.
	logic [7:0] cfg0_q, cfg1_q;

	function automatic obcfg_osc_type dec_osc(input logic [2:0] f);
		case (f)
			3'h7:    dec_osc = OBCFG_OSC_EXT_CLK;
			3'h6:    dec_osc = OBCFG_OSC_INT_RC;
			// Both external RC codes share one setting.
			3'h5,
			3'h4:    dec_osc = OBCFG_OSC_EXT_RC;
			3'h3:    dec_osc = OBCFG_OSC_LP;
			3'h2:    dec_osc = OBCFG_OSC_MP;
			3'h1:    dec_osc = OBCFG_OSC_MS;
			default: dec_osc = OBCFG_OSC_HS;
		endcase
	endfunction

	function automatic obcfg_bor_type dec_bor(input logic [1:0] f);
		case (f)
			2'h3:    dec_bor = OBCFG_BOR_OFF;
			2'h2:    dec_bor = OBCFG_BOR_HIGH;
			2'h1:    dec_bor = OBCFG_BOR_MED;
			default: dec_bor = OBCFG_BOR_LOW;
		endcase
	endfunction

	// Mask-coded parts take their options from parameters; writes are dropped.
	wire       user_wr   = prog_mode && opt_wr && !MASK_ROM;
	wire       wr0       = user_wr && !opt_sel;
	wire       wr1       = user_wr && opt_sel;
	// Reserved bits of byte 0 always stay one.
	wire [7:0] wdata0    = opt_wdata | `OBCFG_B0_RSVD_MASK;
	wire [7:0] src0      = MASK_ROM ? ROM_BYTE0 : nv0_q;
	wire [7:0] src1      = MASK_ROM ? ROM_BYTE1 : nv1_q;
	// Clearing the protect bit in the cell triggers the wipe.
	wire       prot_clr  = wr0 && nv0_q[`OBCFG_B0_PROT_BIT] && !opt_wdata[`OBCFG_B0_PROT_BIT];

	// The cells keep their value through rst_n; only a programming write outside reset changes them.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			nv0_q <= nv0_q;
			nv1_q <= nv1_q;
		end else begin
			if (wr0)
				nv0_q <= wdata0;
			if (wr1)
				nv1_q <= opt_wdata;
		end
	end

	// Reset takes a fresh copy; writes reach the decoded outputs only after the next reset.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cfg0_q <= src0;
			cfg1_q <= src1;
		end
	end

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire       prot_on     = cfg0_q[`OBCFG_B0_PROT_BIT];
	wire [2:0] osc_field   = cfg1_q[`OBCFG_B1_OSC_HI:`OBCFG_B1_OSC_LO];
	wire [1:0] bor_field   = cfg1_q[`OBCFG_B1_BOR_HI:`OBCFG_B1_BOR_LO];
	wire       halt_rst_en = cfg1_q[`OBCFG_B1_HALT_BIT];
	wire       wd_hw       = !cfg1_q[`OBCFG_B1_WDMODE_BIT];
	// Software can only switch the watchdog on; it stays on until the next reset.
	wire       wd_act_d    = wd_hw || wdg_active || watchdog_mode_bit_enable;

	// No reset here: these follow cfg through reset and settle on its second edge.
	always_ff @(posedge sys_clk) begin
		pkg_large                 <= cfg0_q[`OBCFG_B0_PKG_BIT];
		read_protect_bit          <= prot_on;
		clock_guard_en            <= !cfg1_q[`OBCFG_B1_GUARD_BIT];
		main_clock_source_select  <= dec_osc(osc_field);
		brownout_threshold_select <= dec_bor(bor_field);
		halt_entry_reset_bit      <= halt_rst_en;
		watchdog_mode_bit         <= cfg1_q[`OBCFG_B1_WDMODE_BIT];
	end

	// ----------------------------------------
	// Watchdog and halt
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wdg_active     <= 1'b0;
			halt_reset_req <= 1'b0;
		end else begin
			wdg_active     <= wd_act_d;
			halt_reset_req <= halt_entry && wdg_active && cfg1_q[`OBCFG_B1_HALT_BIT];
		end
	end

	// ----------------------------------------
	// External read path
	// ----------------------------------------
	// EEPROM reads ignore protection; program reads are blocked while protected.
	// Protect changes reach this path only after the next reset.
	wire       mem_block = ext_mem_rd && prot_on;
	wire [7:0] mem_val   = cell_erased ? `OBCFG_ERASED_BYTE : mem_rdata;
	wire [7:0] rd_val    = ext_ee_rd ? mem_rdata :
	                       (ext_mem_rd && !prot_on) ? mem_val : 8'h00;
	wire [7:0] opt_val   = !prog_mode ? 8'h00 : (opt_sel ? src1 : src0);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ext_rdata   <= 8'h00;
			ext_blocked <= 1'b0;
			opt_rdata   <= 8'h00;
		end else begin
			ext_rdata   <= rd_val;
			ext_blocked <= mem_block && !ext_ee_rd;
			opt_rdata   <= opt_val;
		end
	end

	// ----------------------------------------
	// Wipe on protect clear
	// ----------------------------------------
	logic              wipe_we_w;
	logic [ADDR_W-1:0] wipe_addr_w;
	logic              busy_w;

	// A trigger that arrives while a wipe runs is ignored by the sequencer.

	obcfg_wipe #(
		.ADDR_W    (ADDR_W)
	) u_wipe (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.start     (prot_clr),
		.busy      (busy_w),
		.wipe_we   (wipe_we_w),
		.wipe_addr (wipe_addr_w)
	);

	// Registered so every top output leaves a flip-flop; memory sees the address one cycle later.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wipe_we   <= 1'b0;
			wipe_addr <= '0;
			wipe_busy <= 1'b0;
		end else begin
			wipe_we   <= wipe_we_w;
			wipe_addr <= wipe_addr_w;
			wipe_busy <= busy_w;
		end
	end

endmodule // obcfg_decoder

`default_nettype wire

// ==== rtl/obcfg_map.svh ====
// Option byte decoder constants: field positions, defaults, sizes.
// Assumes inclusion by bare name from the rtl/ folder.
`ifndef OBCFG_MAP_SVH
`define OBCFG_MAP_SVH

// ----------------------------------------
// Byte 0 fields
// ----------------------------------------
`define OBCFG_B0_PKG_BIT      1
`define OBCFG_B0_PROT_BIT     0
`define OBCFG_B0_RSVD_MASK    8'hFC

// ----------------------------------------
// Byte 1 fields
// ----------------------------------------
`define OBCFG_B1_GUARD_BIT    7
`define OBCFG_B1_OSC_HI       6
`define OBCFG_B1_OSC_LO       4
`define OBCFG_B1_BOR_HI       3
`define OBCFG_B1_BOR_LO       2
`define OBCFG_B1_HALT_BIT     1
`define OBCFG_B1_WDMODE_BIT   0

// ----------------------------------------
// Default contents
// ----------------------------------------
`define OBCFG_ERASED_BYTE     8'hFF
`define OBCFG_B0_DEFAULT      8'hFC
`define OBCFG_B1_DEFAULT      8'hEF

// ----------------------------------------
// Sizes
// ----------------------------------------
`define OBCFG_MEM_ADDR_W      14
`define OBCFG_EE_ADDR_W       8

`endif

// ==== rtl/obcfg_pkg.sv ====
// Types for the option byte configuration decoder.
// Assumes nothing of its surroundings.
package obcfg_pkg;

	typedef enum logic [2:0] {
		OBCFG_OSC_HS,
		OBCFG_OSC_MS,
		OBCFG_OSC_MP,
		OBCFG_OSC_LP,
		OBCFG_OSC_EXT_RC,
		OBCFG_OSC_INT_RC,
		OBCFG_OSC_EXT_CLK
	} obcfg_osc_type;

	typedef enum logic [1:0] {
		OBCFG_BOR_LOW,
		OBCFG_BOR_MED,
		OBCFG_BOR_HIGH,
		OBCFG_BOR_OFF
	} obcfg_bor_type;

	typedef enum logic [1:0] {
		OBCFG_WIPE_IDLE,
		OBCFG_WIPE_RUN,
		OBCFG_WIPE_DONE
	} obcfg_wipe_type;

endpackage

// ==== rtl/obcfg_wipe.sv ====
// Program memory wipe sequencer: walks every address once, with one write strobe per address.
// Assumes the memory accepts one write per cycle while wipe_we is high.
`timescale 1ns/1ns
`default_nettype none

`include "obcfg_map.svh"

module obcfg_wipe
	import obcfg_pkg::*;
#(
	parameter int ADDR_W = `OBCFG_MEM_ADDR_W
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// Control
	input  wire logic              start,
	output logic                   busy,
	// Memory write port
	output logic                   wipe_we,
	output logic [ADDR_W-1:0]      wipe_addr
);

	obcfg_wipe_type         state_q, state_d;
	logic [ADDR_W-1:0]      addr_q;
	wire                    last_addr = &addr_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			OBCFG_WIPE_IDLE: if (start) state_d = OBCFG_WIPE_RUN;
			OBCFG_WIPE_RUN:  if (last_addr) state_d = OBCFG_WIPE_DONE;
			OBCFG_WIPE_DONE: state_d = OBCFG_WIPE_IDLE;
			default:         state_d = OBCFG_WIPE_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q <= OBCFG_WIPE_IDLE;
			addr_q  <= '0;
		end else begin
			state_q <= state_d;
			addr_q  <= (state_q == OBCFG_WIPE_RUN) ? addr_q + 1'b1 : '0;
		end
	end

	assign busy      = (state_q != OBCFG_WIPE_IDLE);
	assign wipe_we   = (state_q == OBCFG_WIPE_RUN);
	assign wipe_addr = addr_q;

endmodule // obcfg_wipe

`default_nettype wire

// ==== sim/obcfg_asserts.sv ====
// Port checker for the option byte decoder.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module obcfg_asserts
	import obcfg_pkg::*;
#(parameter int ADDR_W = 4) (
	input wire logic              sys_clk,
	input wire logic              rst_n,
	input wire logic              prog_mode,
	input wire logic [7:0]        opt_rdata,
	input wire logic              ext_mem_rd,
	input wire logic              ext_ee_rd,
	input wire logic [7:0]        mem_rdata,
	input wire logic [7:0]        ext_rdata,
	input wire logic              ext_blocked,
	input wire logic              read_protect_bit,
	input wire logic              wipe_we,
	input wire logic [ADDR_W-1:0] wipe_addr,
	input wire logic              wipe_busy,
	input wire logic              halt_entry,
	input wire logic              wdg_active,
	input wire logic              halt_reset_req,
	input wire logic              halt_entry_reset_bit,
	input wire logic              watchdog_mode_bit,
	input wire logic [2:0]        main_clock_source_select
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_opt_hidden: assert property (!prog_mode |=> opt_rdata == 8'h00)
		else $error("option bytes visible");
	a_prot_block: assert property (read_protect_bit && ext_mem_rd && !ext_ee_rd |=> ext_blocked && ext_rdata == 8'h00)
		else $error("protected read leaked");
	a_ee_open: assert property (ext_ee_rd |=> !ext_blocked && ext_rdata == $past(mem_rdata))
		else $error("eeprom read refused");
	a_wipe_step: assert property (wipe_we && $past(wipe_we) |-> wipe_addr == $past(wipe_addr) + 1'b1)
		else $error("wipe address skipped");
	a_wipe_busy: assert property (wipe_we |-> wipe_busy)
		else $error("wipe write while idle");
	a_halt_rst: assert property (halt_entry && wdg_active && halt_entry_reset_bit |=> halt_reset_req)
		else $error("halt reset missing");
	a_halt_quiet: assert property (!halt_entry_reset_bit |-> !halt_reset_req)
		else $error("halt reset not enabled");
	a_hw_wdog: assert property (!watchdog_mode_bit |=> wdg_active)
		else $error("hardware watchdog off");
	a_cfg_hold: assert property ($past(rst_n) |-> $stable(main_clock_source_select) && $stable(read_protect_bit))
		else $error("config moved after reset");
endmodule // obcfg_asserts
bind obcfg_decoder obcfg_asserts #(.ADDR_W(ADDR_W)) obcfg_asserts_inst (.*);
`default_nettype wire

// ==== sim/obcfg_prog_tool.sv ====
// Programming tool model on the option byte port.
// Assumes the bench calls access from a falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module obcfg_prog_tool (
	input wire logic   sys_clk,
	output logic       prog_mode,
	output logic       opt_wr,
	output logic       opt_sel,
	output logic [7:0] opt_wdata
);
	initial begin
		prog_mode = 0;
		opt_wr = 0;
		opt_sel = 0;
		opt_wdata = 8'h00;
	end
	// Data is scrambled once the strobe drops, so stale values never look valid
	task automatic access(input logic m, w, s, input logic [7:0] d);
		@(negedge sys_clk);
		prog_mode = m;
		opt_wr = w;
		opt_sel = s;
		opt_wdata = d;
		@(negedge sys_clk);
		opt_wr = 0;
		opt_wdata = ~d;
	endtask
endmodule // obcfg_prog_tool
`default_nettype wire

// ==== sim/test_obcfg_decoder.sv ====
// Self-checking bench for the option byte decoder.
// Assumes the tool model drives the option port; wipe shortened to 16 cells.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
	$display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module test_obcfg_decoder
	import obcfg_pkg::*;
;
	localparam int AW = 4;
	logic sys_clk = 0, rst_n = 0, ext_mem_rd = 0, ext_ee_rd = 0, cell_erased = 0;
	logic halt_entry = 0, watchdog_mode_bit_enable = 0, prog_mode, opt_wr, opt_sel;
	logic [7:0] mem_rdata = 8'h00, opt_wdata, opt_rdata, ext_rdata;
	logic ext_blocked, wipe_we, wipe_busy, wdg_active, halt_reset_req, pkg_large;
	logic read_protect_bit, clock_guard_en, halt_entry_reset_bit, watchdog_mode_bit;
	logic [AW-1:0] wipe_addr;
	obcfg_osc_type main_clock_source_select;
	obcfg_bor_type brownout_threshold_select;
	int n_mismatch = 0, n_compared = 0;
	const obcfg_osc_type osc_exp [8] = '{OBCFG_OSC_HS, OBCFG_OSC_MS, OBCFG_OSC_MP, OBCFG_OSC_LP,
		OBCFG_OSC_EXT_RC, OBCFG_OSC_EXT_RC, OBCFG_OSC_INT_RC, OBCFG_OSC_EXT_CLK};
	obcfg_decoder #(.ADDR_W(AW)) obcfg_decoder_inst (.*);
	obcfg_prog_tool obcfg_prog_tool_inst (.*);
	// Mask-coded twin on the same inputs: its options come from parameters only
	localparam logic [7:0] MASK_B0 = 8'hFE;
	localparam logic [7:0] MASK_B1 = 8'h2A;
	logic [7:0] m_opt_rdata;
	logic m_pkg_large, m_wdg_active;
	obcfg_osc_type m_osc;
	obcfg_decoder #(.ADDR_W(AW), .MASK_ROM(1'b1), .ROM_BYTE0(MASK_B0), .ROM_BYTE1(MASK_B1)) obcfg_decoder_mask_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .prog_mode(prog_mode), .opt_wr(opt_wr), .opt_sel(opt_sel),
		.opt_wdata(opt_wdata), .opt_rdata(m_opt_rdata), .ext_mem_rd(ext_mem_rd), .ext_ee_rd(ext_ee_rd),
		.cell_erased(cell_erased), .mem_rdata(mem_rdata), .ext_rdata(), .ext_blocked(), .wipe_we(),
		.wipe_addr(), .wipe_busy(), .halt_entry(halt_entry), .watchdog_mode_bit_enable(watchdog_mode_bit_enable),
		.wdg_active(m_wdg_active), .halt_reset_req(), .pkg_large(m_pkg_large), .read_protect_bit(),
		.clock_guard_en(), .main_clock_source_select(m_osc), .brownout_threshold_select(),
		.halt_entry_reset_bit(), .watchdog_mode_bit());
	initial forever #25 sys_clk = ~sys_clk;
	task automatic cyc(int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic do_reset();
		rst_n = 0;
		cyc(3);
		rst_n = 1;
		cyc(1);
	endtask
	task automatic end_sim();
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic t_power();
		`CHK(pkg_large, 1'b1)
		`CHK(read_protect_bit, 1'b1)
		`CHK(main_clock_source_select, OBCFG_OSC_EXT_CLK)
		`CHK(brownout_threshold_select, OBCFG_BOR_OFF)
		`CHK(clock_guard_en, 1'b0)
		obcfg_prog_tool_inst.access(0, 1, 0, 8'h00);
		`CHK(opt_rdata, 8'h00)
		obcfg_prog_tool_inst.access(1, 0, 0, 8'h00);
		`CHK(opt_rdata, 8'hFF)
	endtask
	task automatic t_protect();
		ext_mem_rd = 1;
		mem_rdata = 8'h5A;
		cyc(1);
		`CHK({ext_blocked, ext_rdata}, 9'h100)
		ext_mem_rd = 0;
		ext_ee_rd = 1;
		cyc(1);
		`CHK({ext_blocked, ext_rdata}, 9'h05A)
		ext_ee_rd = 0;
	endtask
	task automatic t_wipe();
		int n = 0;
		obcfg_prog_tool_inst.access(1, 1, 0, 8'hFE);
		repeat (40) begin
			cyc(1);
			if (wipe_we) begin
				`CHK(wipe_addr, AW'(n))
				n++;
			end
		end
		`CHK(n, 1 << AW)
		`CHK(wipe_busy, 1'b0)
		do_reset();
		ext_mem_rd = 1;
		cell_erased = 1;
		cyc(1);
		`CHK({ext_blocked, ext_rdata}, 9'h0FF)
		ext_mem_rd = 0;
		cell_erased = 0;
	endtask
	task automatic t_cfg();
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			obcfg_prog_tool_inst.access(1, 1, 0, {6'h00, c[0], 1'b0});
			obcfg_prog_tool_inst.access(1, 1, 1, {c[0], c, c[1:0], c[1], c[2]});
			do_reset();
			`CHK(pkg_large, c[0])
			`CHK(clock_guard_en, ~c[0])
			`CHK(main_clock_source_select, osc_exp[i])
			`CHK(brownout_threshold_select, obcfg_bor_type'(c[1:0]))
			`CHK(wdg_active, ~c[2])
			`CHK(watchdog_mode_bit, c[2])
			`CHK(halt_entry_reset_bit, c[1])
			halt_entry = 1;
			cyc(1);
			halt_entry = 0;
			`CHK(halt_reset_req, c[1] & ~c[2])
			watchdog_mode_bit_enable = 1;
			cyc(1);
			`CHK(wdg_active, 1'b1)
			halt_entry = 1;
			cyc(1);
			halt_entry = 0;
			`CHK(halt_reset_req, c[1])
			watchdog_mode_bit_enable = 0;
		end
	endtask
	task automatic t_mask();
		obcfg_prog_tool_inst.access(1, 1, 1, 8'h00);
		`CHK(main_clock_source_select, OBCFG_OSC_EXT_CLK)
		do_reset();
		`CHK(main_clock_source_select, OBCFG_OSC_HS)
		`CHK(m_osc, OBCFG_OSC_MP)
		`CHK(m_opt_rdata, MASK_B1)
		`CHK(m_pkg_large, 1'b1)
		`CHK(m_wdg_active, 1'b1)
	endtask
	initial begin
		cyc(10);
		rst_n = 1;
		cyc(1);
		t_power();
		t_protect();
		t_wipe();
		t_cfg();
		t_mask();
		end_sim();
	end
	// Roughly thirteen times the expected run length
	initial begin
		#100000;
		n_mismatch++;
		end_sim();
	end
endmodule // test_obcfg_decoder
`default_nettype wire
